// File: rtl/virt_caps_regs.svh
/*
  Register indices, field positions, default-one masks and reset values of
  the capability block. Assumes inclusion by bare name from the rtl folder.
*/
`ifndef VIRT_CAPS_REGS_SVH
`define VIRT_CAPS_REGS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_EXIT_CAPS 32'h0000_0483
`define IDX_ENTRY_CAPS 32'h0000_0484
`define IDX_MISC_LIMITS 32'h0000_0485
`define IDX_MW_FIXED_ONES 32'h0000_0486
`define IDX_MW_ALLOWED_ONES 32'h0000_0487
`define IDX_FW_FIXED_ONES 32'h0000_0488
`define IDX_FW_ALLOWED_ONES 32'h0000_0489
`define IDX_SECONDARY_CAPS 32'h0000_048b
`define IDX_FULL_EXIT_CAPS 32'h0000_048f
`define IDX_FULL_ENTRY_CAPS 32'h0000_0490

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define BASIC_TRUE_BIT 55
`define PRIMARY_SEC_ALLOWED_BIT 63
`define EXIT_DEFAULT_ONE_MASK 32'h0003_6dff
`define ENTRY_DEFAULT_ONE_MASK 32'h0000_11ff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD 64'h0000_0000_0000_0000
`define RST_TIMER 32'h0000_0000

`endif

// File: rtl/virt_caps_pkg.sv
/*
  Types shared by the capability block and its users.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package virt_caps_pkg;

  // Activity state requested by a guest entry
  typedef enum logic [1:0] {
    ACT_ACTIVE = 2'b00,
    ACT_HALT = 2'b01,
    ACT_SHUTDOWN = 2'b10,
    ACT_WAIT_STARTUP = 2'b11
  } act_state_t;

  // Control words presented with an entry request
  typedef struct packed {
    logic sec_enable;
    logic [31:0] sec_ctls;
    logic [31:0] exit_ctls;
    logic [31:0] entry_ctls;
    act_state_t activity;
  } entry_req_t;

  // One flag per failing check
  typedef struct packed {
    logic secondary;
    logic exit_ctl;
    logic exit_default_one;
    logic entry_ctl;
    logic entry_default_one;
    logic activity;
  } fail_cause_t;

endpackage

// File: rtl/virt_capability_entry_checks.sv
/*
  Capability register bank of the virtualization extension, the checks that
  a guest entry must pass, the preemption timer rate divider and the forcing
  of fixed bits in the machine and feature control words.
  Assumes all inputs are synchronous to ref_clk_i and that requests are
  single-cycle pulses from the core pipeline.
*/
`timescale 1ns/1ps
`include "virt_caps_regs.svh"

module virt_capability_entry_checks #(
  parameter logic BASIC_TRUE_CTLS = 1'b1, // Bit 55 of the basic register
  parameter logic PRIMARY_SEC_ALLOWED = 1'b1, // Bit 63 of primary caps
  parameter logic [31:0] SEC_ALLOWED_ONES = 32'h0000_00ff,
  parameter logic [63:0] EXIT_CAPS = 64'h0003_ffff_0000_0000,
  parameter logic [63:0] FULL_EXIT_CAPS = 64'h0003_ffff_0000_0000,
  parameter logic [63:0] ENTRY_CAPS = 64'h0000_13ff_0000_0000,
  parameter logic [63:0] FULL_ENTRY_CAPS = 64'h0000_13ff_0000_0000,
  parameter logic [4:0] TIMER_RATE_SHIFT = 5'h05,
  parameter logic [2:0] ACT_SUPPORT = 3'h7, // Halt, shutdown, startup wait
  parameter logic [8:0] BASE_TARGET_COUNT = 9'h004, // 0 to 256
  parameter logic [2:0] LIST_SCALE = 3'h0,
  parameter logic [31:0] MONITOR_REVISION = 32'h0000_0001, // Arbitrary value
  parameter logic [63:0] MW_FIXED_ONES = 64'h0000_0000_8000_0021,
  parameter logic [63:0] MW_ALLOWED_ONES = 64'h0000_0000_ffff_ffff,
  parameter logic [63:0] FW_FIXED_ONES = 64'h0000_0000_0000_2000,
  parameter logic [63:0] FW_ALLOWED_ONES = 64'h0000_0000_0000_67ff
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Capability register reads
  input wire logic cap_rd_i,
  input wire logic [31:0] cap_index_i,
  output logic cap_valid_o,
  output logic cap_fault_o,
  output logic [63:0] cap_data_o,
  // Guest entry checks
  input wire logic entry_req_i,
  input wire virt_caps_pkg::entry_req_t entry_ctl_i,
  output logic entry_done_o,
  output logic entry_fail_o,
  output virt_caps_pkg::fail_cause_t fail_cause_o,
  // Control words
  input wire logic virt_on_i,
  input wire logic mcw_wr_i,
  input wire logic [63:0] mcw_wdata_i,
  input wire logic fcw_wr_i,
  input wire logic [63:0] fcw_wdata_i,
  output logic [63:0] machine_control_word_o,
  output logic [63:0] feature_control_word_o,
  // Timestamp counter and preemption timer
  input wire logic tsc_inc_i,
  input wire logic timer_active_i,
  input wire logic timer_load_i,
  input wire logic [31:0] timer_load_val_i,
  output logic [63:0] timestamp_counter_o,
  output logic [31:0] timer_o,
  output logic timer_expire_o
);
  import virt_caps_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Any bit cleared where allowed-zero forbids it, or set where allowed-one forbids
  function automatic logic ctl_violation(input logic [31:0] ctl, input logic [63:0] caps);
    ctl_violation = |((~ctl & caps[31:0]) | (ctl & ~caps[63:32]));
  endfunction

  // Force fixed-one bits high and disallowed bits low
  function automatic logic [63:0] force_fixed(input logic [63:0] v, input logic [63:0] f1,
                                              input logic [63:0] a1);
    force_fixed = (v | f1) & a1;
  endfunction

  // ----------------------------------------
  // Reported capability values
  // ----------------------------------------

  // Secondary register: low half is hardwired zero
  wire logic [63:0] sec_caps_rd = {SEC_ALLOWED_ONES, 32'h0000_0000};
  // Legacy exit register: default-one bits always read as one
  wire logic [63:0] exit_caps_rd = EXIT_CAPS | {32'h0000_0000, `EXIT_DEFAULT_ONE_MASK};
  // Legacy entry register: default-one bits always read as one
  wire logic [63:0] entry_caps_rd = ENTRY_CAPS | {32'h0000_0000, `ENTRY_DEFAULT_ONE_MASK};
  // True registers carry no always-one exceptions
  wire logic [63:0] full_exit_rd = FULL_EXIT_CAPS;
  wire logic [63:0] full_entry_rd = FULL_ENTRY_CAPS;
  // A fixed-one bit is always also allowed-one, whatever the parameters say
  wire logic [63:0] mw_allowed_rd = MW_ALLOWED_ONES | MW_FIXED_ONES;
  wire logic [63:0] fw_allowed_rd = FW_ALLOWED_ONES | FW_FIXED_ONES;
  // Miscellaneous limits; count stored in plain binary, reserved fields zero
  wire logic [8:0] base_count = (BASE_TARGET_COUNT > 9'h100) ? 9'h100 : BASE_TARGET_COUNT;
  wire logic [63:0] misc_rd = {
    MONITOR_REVISION,
    4'h0,
    LIST_SCALE, // Software keeps lists within 512*(N+1)
    base_count,
    7'h00,
    ACT_SUPPORT,
    1'b0,
    TIMER_RATE_SHIFT
  };

  // ----------------------------------------
  // Capability read decode
  // ----------------------------------------

  // Presence of optional registers
  wire logic sec_present = PRIMARY_SEC_ALLOWED;
  wire logic true_present = BASIC_TRUE_CTLS;

  // Hit and data for the requested index
  logic rd_hit;
  logic [63:0] rd_word;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 64'h0000_0000_0000_0000;
    case (cap_index_i)
      `IDX_EXIT_CAPS: rd_word = exit_caps_rd;
      `IDX_ENTRY_CAPS: rd_word = entry_caps_rd;
      `IDX_MISC_LIMITS: rd_word = misc_rd;
      `IDX_MW_FIXED_ONES: rd_word = MW_FIXED_ONES;
      `IDX_MW_ALLOWED_ONES: rd_word = mw_allowed_rd;
      `IDX_FW_FIXED_ONES: rd_word = FW_FIXED_ONES;
      `IDX_FW_ALLOWED_ONES: rd_word = fw_allowed_rd;
      // Absent registers fault like any unknown index
      `IDX_SECONDARY_CAPS:
      begin
        rd_hit = sec_present;
        rd_word = sec_present ? sec_caps_rd : 64'h0000_0000_0000_0000;
      end
      `IDX_FULL_EXIT_CAPS:
      begin
        rd_hit = true_present;
        rd_word = true_present ? full_exit_rd : 64'h0000_0000_0000_0000;
      end
      `IDX_FULL_ENTRY_CAPS:
      begin
        rd_hit = true_present;
        rd_word = true_present ? full_entry_rd : 64'h0000_0000_0000_0000;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read answer registers, one cycle after the request
  logic cap_valid_r;
  logic cap_fault_r;
  logic [63:0] cap_data_r;
  logic [31:0] cap_index_r; // Index of the last read, kept for checking
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cap_valid_r <= 1'b0;
      cap_fault_r <= 1'b0;
      cap_data_r <= `RST_WORD;
      cap_index_r <= 32'h0000_0000;
    end
    else
    begin
      cap_valid_r <= cap_rd_i;
      cap_fault_r <= cap_rd_i & ~rd_hit;
      if (cap_rd_i)
      begin
        cap_data_r <= rd_word;
        cap_index_r <= cap_index_i;
      end
    end
  end
  assign cap_valid_o = cap_valid_r;
  assign cap_fault_o = cap_fault_r;
  assign cap_data_o = cap_data_r;

  // ----------------------------------------
  // Guest entry checks
  // ----------------------------------------

  // Applicable capability set depends on true-control support
  wire logic [63:0] exit_apply = true_present ? full_exit_rd : exit_caps_rd;
  wire logic [63:0] entry_apply = true_present ? full_entry_rd : entry_caps_rd;

  // Secondary controls matter only when enabled; low half is all zero
  wire logic chk_sec = entry_ctl_i.sec_enable & ctl_violation(entry_ctl_i.sec_ctls,
                                                              sec_caps_rd);
  // Exit controls against both halves of the applicable register
  wire logic chk_exit = ctl_violation(entry_ctl_i.exit_ctls, exit_apply);
  // Legacy mode insists on every default-one exit control being one
  wire logic chk_exit_d1 = ~true_present &
    (|(~entry_ctl_i.exit_ctls & `EXIT_DEFAULT_ONE_MASK));
  // Entry controls against both halves of the applicable register
  wire logic chk_entry = ctl_violation(entry_ctl_i.entry_ctls, entry_apply);
  // Legacy mode insists on every default-one entry control being one
  wire logic chk_entry_d1 = ~true_present &
    (|(~entry_ctl_i.entry_ctls & `ENTRY_DEFAULT_ONE_MASK));
  // Active state is always accepted; others need their support flag
  logic chk_act;
  always_comb
  begin
    case (entry_ctl_i.activity)
      ACT_ACTIVE: chk_act = 1'b0;
      ACT_HALT: chk_act = ~ACT_SUPPORT[0];
      ACT_SHUTDOWN: chk_act = ~ACT_SUPPORT[1];
      ACT_WAIT_STARTUP: chk_act = ~ACT_SUPPORT[2];
      default: chk_act = 1'b1;
    endcase
  end

  // All checks are collected so software sees every cause at once
  wire fail_cause_t cause_now = '{
    secondary: chk_sec,
    exit_ctl: chk_exit,
    exit_default_one: chk_exit_d1,
    entry_ctl: chk_entry,
    entry_default_one: chk_entry_d1,
    activity: chk_act
  };

  // Outcome registers; done follows the request every cycle, fail and causes update only on a request
  logic entry_done_r;
  logic entry_fail_r;
  fail_cause_t fail_cause_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      entry_done_r <= 1'b0;
      entry_fail_r <= 1'b0;
      fail_cause_r <= '0;
    end
    else
    begin
      entry_done_r <= entry_req_i;
      if (entry_req_i)
      begin
        entry_fail_r <= |cause_now;
        fail_cause_r <= cause_now;
      end
    end
  end
  assign entry_done_o = entry_done_r;
  assign entry_fail_o = entry_fail_r;
  assign fail_cause_o = fail_cause_r;

  // ----------------------------------------
  // Control words with fixed bits
  // ----------------------------------------

  // New value before forcing; forcing re-applies every cycle while active
  wire logic [63:0] mcw_raw = mcw_wr_i ? mcw_wdata_i : machine_control_word_o;
  wire logic [63:0] fcw_raw = fcw_wr_i ? fcw_wdata_i : feature_control_word_o;
  wire logic [63:0] mcw_nxt = virt_on_i ? force_fixed(mcw_raw, MW_FIXED_ONES,
                                                      mw_allowed_rd) : mcw_raw;
  wire logic [63:0] fcw_nxt = virt_on_i ? force_fixed(fcw_raw, FW_FIXED_ONES,
                                                      fw_allowed_rd) : fcw_raw;

  // Word registers
  logic [63:0] mcw_r;
  logic [63:0] fcw_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      mcw_r <= `RST_WORD;
      fcw_r <= `RST_WORD;
    end
    else
    begin
      mcw_r <= mcw_nxt;
      fcw_r <= fcw_nxt;
    end
  end
  assign machine_control_word_o = mcw_r;
  assign feature_control_word_o = fcw_r;

  // ----------------------------------------
  // Timestamp counter and preemption timer
  // ----------------------------------------

  // Counter advances on the increment enable pulse
  logic [63:0] tsc_r;
  wire logic [63:0] tsc_nxt = tsc_r + 64'h0000_0000_0000_0001;
  // Bit X toggles in this increment: the timer's tick enable
  wire logic [63:0] tsc_flip = tsc_r ^ tsc_nxt;
  wire logic timer_tick = tsc_inc_i & tsc_flip[TIMER_RATE_SHIFT];
  logic [31:0] timer_r;
  // Timer steps down only while active and not yet at zero
  wire logic timer_step = timer_active_i & timer_tick & (timer_r != 32'h0000_0000);
  logic timer_expire_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      tsc_r <= `RST_WORD;
      timer_r <= `RST_TIMER;
      timer_expire_r <= 1'b0;
    end
    else
    begin
      if (tsc_inc_i)
        tsc_r <= tsc_nxt;
      // Load wins over a tick in the same cycle
      if (timer_load_i)
        timer_r <= timer_load_val_i;
      else if (timer_step)
        timer_r <= timer_r - 32'h0000_0001;
      timer_expire_r <= ~timer_load_i & timer_step & (timer_r == 32'h0000_0001);
    end
  end
  assign timestamp_counter_o = tsc_r;
  assign timer_o = timer_r;
  assign timer_expire_o = timer_expire_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Secondary reads return a zero low half
  property p_sec_low_zero;
    cap_valid_o && !cap_fault_o && cap_index_r == `IDX_SECONDARY_CAPS
      |-> cap_data_o[31:0] == 32'h0000_0000;
  endproperty
  a_sec_low_zero: assert property (p_sec_low_zero) else $error("secondary low half set");

  // Default-one exit bits read as one
  property p_exit_d1;
    cap_valid_o && cap_index_r == `IDX_EXIT_CAPS
      |-> (cap_data_o[31:0] & `EXIT_DEFAULT_ONE_MASK) == `EXIT_DEFAULT_ONE_MASK;
  endproperty
  a_exit_d1: assert property (p_exit_d1) else $error("exit default-one bit reads zero");

  // Default-one entry bits read as one
  property p_entry_d1;
    cap_valid_o && cap_index_r == `IDX_ENTRY_CAPS
      |-> (cap_data_o[31:0] & `ENTRY_DEFAULT_ONE_MASK) == `ENTRY_DEFAULT_ONE_MASK;
  endproperty
  a_entry_d1: assert property (p_entry_d1) else $error("entry default-one bit reads zero");

  // True exit register faults without true-control support
  property p_true_absent;
    cap_rd_i && cap_index_i == `IDX_FULL_EXIT_CAPS && !BASIC_TRUE_CTLS
      |=> cap_valid_o && cap_fault_o;
  endproperty
  a_true_absent: assert property (p_true_absent) else $error("true exit register present");

  // Reserved misc fields read zero
  property p_misc_res;
    cap_valid_o && cap_index_r == `IDX_MISC_LIMITS
      |-> cap_data_o[5] == 1'b0 && cap_data_o[15:9] == 7'h00 && cap_data_o[31:28] == 4'h0;
  endproperty
  a_misc_res: assert property (p_misc_res) else $error("misc reserved bit set");

  // Disabled secondary controls never fail the entry
  property p_sec_ignored;
    entry_req_i && !entry_ctl_i.sec_enable |=> entry_done_o && !fail_cause_o.secondary;
  endproperty
  a_sec_ignored: assert property (p_sec_ignored) else $error("disabled secondary failed");

  // Active state never raises the activity cause
  property p_act0;
    entry_req_i && entry_ctl_i.activity == ACT_ACTIVE |=> !fail_cause_o.activity;
  endproperty
  a_act0: assert property (p_act0) else $error("active state refused");

  // Single outcome equals the OR of all causes
  property p_merge;
    entry_done_o |-> entry_fail_o == (|fail_cause_o);
  endproperty
  a_merge: assert property (p_merge) else $error("outcome and causes disagree");

  // Machine word obeys fixed bits after a cycle of operation
  property p_mcw_fixed;
    virt_on_i |=> (machine_control_word_o & MW_FIXED_ONES) == MW_FIXED_ONES
      && (machine_control_word_o & ~mw_allowed_rd) == 64'h0000_0000_0000_0000;
  endproperty
  a_mcw_fixed: assert property (p_mcw_fixed) else $error("machine word fixed bit wrong");

  // Feature word obeys fixed bits after a cycle of operation
  property p_fcw_fixed;
    virt_on_i |=> (feature_control_word_o & FW_FIXED_ONES) == FW_FIXED_ONES
      && (feature_control_word_o & ~fw_allowed_rd) == 64'h0000_0000_0000_0000;
  endproperty
  a_fcw_fixed: assert property (p_fcw_fixed) else $error("feature word fixed bit wrong");

  // Timer drops by exactly one per tick of bit X
  property p_timer_step;
    timer_active_i && tsc_inc_i && tsc_flip[TIMER_RATE_SHIFT] && !timer_load_i && timer_o != 0
      |=> timer_o == $past(timer_o) - 32'h0000_0001;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer step wrong");

endmodule

// File: dv/cap_reader_model.sv
/*
  Software side model: issues capability reads one at a time and waits a
  bounded time for the answer.
  Assumes the block answers one cycle after the request pulse.
*/
`timescale 1ns/1ps

module cap_reader_model (
  // Clock
  input wire logic clk_i,
  // Read request towards the block
  output logic rd_o,
  output logic [31:0] idx_o,
  // Answer from the block
  input wire logic valid_i,
  input wire logic fault_i,
  input wire logic [63:0] data_i
);
  // Idle cycles before each read, so the caller can be slow
  int gap = 0;

  // Quiet bus at time zero
  initial
  begin
    rd_o = 1'b0;
    idx_o = 32'h0000_0000;
  end

  // ----------------------------------------
  // One read; ok low when no answer came
  // ----------------------------------------
  task automatic read(input logic [31:0] idx, output logic [63:0] d,
    output logic f, output logic ok);
    int n;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rd_o <= 1'b1;
    idx_o <= idx;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    n = 0;
    // Bounded wait, a hung block must not hang the run
    while (valid_i !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ok = (valid_i === 1'b1);
    d = data_i;
    f = fault_i;
  endtask

  // Longest load or store list this caller allows itself
  function automatic int list_limit(input logic [63:0] misc);
    return 512 * (int'(misc[27:25]) + 1);
  endfunction
endmodule

// File: dv/virt_capability_entry_checks_test.sv
/*
  Self-checking bench: a true-mode and a legacy-mode block side by side,
  register reads, entry checks, control words and the preemption timer.
  Assumes the rtl folder is on the include path.
*/
`timescale 1ns/1ps
`include "virt_caps_regs.svh"

module virt_capability_entry_checks_test;
  import virt_caps_pkg::*;
  // Capability contents under test
  localparam logic [63:0] EXC = 64'h0003_ffff_0000_0000;
  localparam logic [63:0] FEXC = 64'h0002_fff7_0000_0010;
  localparam logic [63:0] ENC = 64'h0000_13ff_0000_0000;
  localparam logic [63:0] FENC = 64'h0000_13ff_0000_0001;
  localparam logic [31:0] SEC1 = 32'h0000_00f5;
  localparam logic [4:0] TRS = 5'h02;
  localparam logic [2:0] ACT = 3'h5; // No shutdown state
  localparam logic [8:0] BTC = 9'h100;
  localparam logic [2:0] LSC = 3'h2;
  localparam logic [31:0] MREV = 32'h0000_5a5a; // Arbitrary revision value
  localparam logic [63:0] MWF = 64'h0000_0000_8000_0021;
  localparam logic [63:0] MWA = 64'h0000_0000_e005_003f;
  localparam logic [63:0] FWF = 64'h0000_0000_0000_2000;
  localparam logic [63:0] FWA = 64'h0000_0000_0000_47ff;
  // Ports, named as the block names them
  logic ref_clk_i, rst_n_i, entry_req_i, virt_on_i, mcw_wr_i, fcw_wr_i;
  logic tsc_inc_i, timer_active_i, timer_load_i, cap_valid_o, cap_fault_o;
  logic entry_done_o, entry_fail_o, timer_expire_o, l_valid, l_fault, l_done, l_fail;
  logic [63:0] cap_data_o, mcw_wdata_i, fcw_wdata_i, l_data, mv, fv;
  logic [63:0] machine_control_word_o, feature_control_word_o, timestamp_counter_o;
  logic [31:0] timer_o, timer_load_val_i;
  wire cap_rd_i;
  wire [31:0] cap_index_i;
  entry_req_t entry_ctl_i;
  fail_cause_t fail_cause_o, l_cause;
  int n_mismatch = 0, samples_checked = 0, n_expire = 0, tsc_n = 0;

  virt_capability_entry_checks #(
    .EXIT_CAPS(EXC), .FULL_EXIT_CAPS(FEXC), .ENTRY_CAPS(ENC), .FULL_ENTRY_CAPS(FENC),
    .SEC_ALLOWED_ONES(SEC1), .TIMER_RATE_SHIFT(TRS), .ACT_SUPPORT(ACT),
    .BASE_TARGET_COUNT(BTC), .LIST_SCALE(LSC), .MONITOR_REVISION(MREV),
    .MW_FIXED_ONES(MWF), .MW_ALLOWED_ONES(MWA), .FW_FIXED_ONES(FWF), .FW_ALLOWED_ONES(FWA)
  ) dut (.*);

  // Legacy twin: true registers absent, default-one checks live
  virt_capability_entry_checks #(.BASIC_TRUE_CTLS(1'b0), .PRIMARY_SEC_ALLOWED(1'b0),
    .EXIT_CAPS(EXC), .FULL_EXIT_CAPS(FEXC), .ENTRY_CAPS(ENC), .FULL_ENTRY_CAPS(FENC),
    .SEC_ALLOWED_ONES(SEC1), .TIMER_RATE_SHIFT(TRS), .ACT_SUPPORT(ACT),
    .BASE_TARGET_COUNT(BTC), .LIST_SCALE(LSC), .MONITOR_REVISION(MREV),
    .MW_FIXED_ONES(MWF), .MW_ALLOWED_ONES(MWA), .FW_FIXED_ONES(FWF), .FW_ALLOWED_ONES(FWA)
  ) dut_legacy (
    .cap_valid_o(l_valid), .cap_fault_o(l_fault), .cap_data_o(l_data),
    .entry_done_o(l_done), .entry_fail_o(l_fail), .fail_cause_o(l_cause),
    .machine_control_word_o(), .feature_control_word_o(), .timestamp_counter_o(),
    .timer_o(), .timer_expire_o(), .*);

  cap_reader_model rdr (.clk_i(ref_clk_i), .rd_o(cap_rd_i), .idx_o(cap_index_i),
    .valid_i(cap_valid_o), .fault_i(cap_fault_o), .data_i(cap_data_o));

  // 200 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // Expire pulses seen, sampled before the edge's updates land
  always @(posedge ref_clk_i)
    if (timer_expire_o === 1'b1)
      n_expire++;

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [64:0] exp_reg(input logic [31:0] i, input logic lg);
    logic [63:0] m;
    m = {MREV, 4'h0, LSC, BTC, 7'h00, ACT, 1'b0, TRS};
    case (i)
      `IDX_EXIT_CAPS: return {1'b0, EXC[63:32], EXC[31:0] | `EXIT_DEFAULT_ONE_MASK};
      `IDX_ENTRY_CAPS: return {1'b0, ENC[63:32], ENC[31:0] | `ENTRY_DEFAULT_ONE_MASK};
      `IDX_MISC_LIMITS: return {1'b0, m};
      `IDX_MW_FIXED_ONES: return {1'b0, MWF};
      `IDX_MW_ALLOWED_ONES: return {1'b0, MWA | MWF};
      `IDX_FW_FIXED_ONES: return {1'b0, FWF};
      `IDX_FW_ALLOWED_ONES: return {1'b0, FWA | FWF};
      `IDX_SECONDARY_CAPS: return lg ? {1'b1, 64'h0} : {1'b0, SEC1, 32'h0000_0000};
      // True registers vanish in legacy mode
      `IDX_FULL_EXIT_CAPS: return lg ? {1'b1, 64'h0} : {1'b0, FEXC};
      `IDX_FULL_ENTRY_CAPS: return lg ? {1'b1, 64'h0} : {1'b0, FENC};
      default: return {1'b1, 64'h0};
    endcase
  endfunction

  function automatic fail_cause_t exp_cause(input entry_req_t c, input logic lg);
    fail_cause_t f;
    logic [63:0] x, n;
    x = lg ? {EXC[63:32], EXC[31:0] | `EXIT_DEFAULT_ONE_MASK} : FEXC;
    n = lg ? {ENC[63:32], ENC[31:0] | `ENTRY_DEFAULT_ONE_MASK} : FENC;
    f.secondary = c.sec_enable & (|(c.sec_ctls & ~SEC1));
    f.exit_ctl = (|(~c.exit_ctls & x[31:0])) | (|(c.exit_ctls & ~x[63:32]));
    f.exit_default_one = lg & (|(~c.exit_ctls & `EXIT_DEFAULT_ONE_MASK));
    f.entry_ctl = (|(~c.entry_ctls & n[31:0])) | (|(c.entry_ctls & ~n[63:32]));
    f.entry_default_one = lg & (|(~c.entry_ctls & `ENTRY_DEFAULT_ONE_MASK));
    f.activity = (c.activity != ACT_ACTIVE) & ~ACT[c.activity - 2'd1];
    return f;
  endfunction

  // Mostly legal words with a single bit sometimes knocked out
  function automatic entry_req_t rand_ctl();
    entry_req_t c;
    logic [31:0] r;
    r = $urandom;
    c.sec_enable = r[0];
    c.sec_ctls = $urandom & SEC1;
    c.exit_ctls = ($urandom | FEXC[31:0]) & FEXC[63:32];
    c.entry_ctls = ($urandom | FENC[31:0]) & FENC[63:32];
    c.activity = act_state_t'(r[2:1]);
    if (r[3])
      c.sec_ctls[r[8:4]] = 1'b1;
    if (r[9])
      c.exit_ctls[r[14:10]] = ~c.exit_ctls[r[14:10]];
    if (r[15])
      c.entry_ctls[r[20:16]] = ~c.entry_ctls[r[20:16]];
    return c;
  endfunction

  // ----------------------------------------
  // Checking and stimulus tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t %s", $time, what);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Read both twins at once; they run in lockstep
  task automatic rd(input logic [31:0] idx);
    logic [63:0] d;
    logic [64:0] e;
    logic f, ok;
    rdr.read(idx, d, f, ok);
    e = exp_reg(idx, 1'b0);
    if (!ok)
    begin
      $display("FAIL t=%0t no answer", $time);
      n_mismatch++;
      final_report();
    end
    else
    begin
      check(d, e[63:0], "read data");
      check(f, e[64], "read fault");
      e = exp_reg(idx, 1'b1);
      check(l_data, e[63:0], "legacy data");
      check(l_fault, e[64], "legacy fault");
    end
  endtask

  task automatic entry(input entry_req_t c);
    fail_cause_t e;
    @(posedge ref_clk_i);
    entry_req_i <= 1'b1;
    entry_ctl_i <= c;
    @(posedge ref_clk_i);
    entry_req_i <= 1'b0;
    #1;
    e = exp_cause(c, 1'b0);
    check(entry_done_o & l_done, 1'b1, "entry done");
    check(fail_cause_o, e, "true causes");
    check(entry_fail_o, |e, "true fail");
    e = exp_cause(c, 1'b1);
    check(l_cause, e, "legacy causes");
    check(l_fail, |e, "legacy fail");
  endtask

  // Write both words; forced at once when operation is on
  task automatic words(input logic von);
    mv = {$urandom, $urandom};
    fv = {$urandom, $urandom};
    @(posedge ref_clk_i);
    virt_on_i <= von;
    mcw_wr_i <= 1'b1;
    mcw_wdata_i <= mv;
    fcw_wr_i <= 1'b1;
    fcw_wdata_i <= fv;
    @(posedge ref_clk_i);
    mcw_wr_i <= 1'b0;
    fcw_wr_i <= 1'b0;
    #1;
    check(machine_control_word_o, von ? (mv | MWF) & (MWA | MWF) : mv, "mword");
    check(feature_control_word_o, von ? (fv | FWF) & (FWA | FWF) : fv, "fword");
  endtask

  // Load, then k counter increments; ticks on every 2**TRS
  task automatic timer_run(input logic act, input int k, input logic [31:0] ld);
    int ticks, ex0;
    ex0 = n_expire;
    @(posedge ref_clk_i);
    timer_active_i <= act;
    timer_load_i <= 1'b1;
    timer_load_val_i <= ld;
    @(posedge ref_clk_i);
    timer_load_i <= 1'b0;
    tsc_inc_i <= 1'b1;
    repeat (k) @(posedge ref_clk_i);
    tsc_inc_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    ticks = ((tsc_n + k) >> TRS) - (tsc_n >> TRS);
    tsc_n += k;
    check(timestamp_counter_o, tsc_n, "counter");
    check(timer_o, !act ? ld : (ld > ticks ? ld - ticks : 0), "timer");
    check(n_expire - ex0, act && ld <= ticks, "expire");
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    $display("FAIL t=%0t run too long", $time);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    entry_req_t c;
    void'($urandom(18129));
    {rst_n_i, entry_req_i, virt_on_i, mcw_wr_i, fcw_wr_i} = 5'h00;
    {tsc_inc_i, timer_active_i, timer_load_i, timer_load_val_i} = 35'h0;
    {mcw_wdata_i, fcw_wdata_i} = 128'h0;
    entry_ctl_i = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check(machine_control_word_o | timer_o | cap_data_o, 64'h0, "reset state");
    // Every index from 483h up, holes and the end included
    for (int i = 0; i < 16; i++)
      rd(32'h0000_0483 + i);
    rdr.gap = 2;
    rd(32'h0000_0000);
    rd(`IDX_SECONDARY_CAPS);
    // Corners: secondary zeros, disabled secondary, unsupported shutdown, startup wait with cleared exit controls
    c = '0;
    c.sec_enable = 1'b1;
    c.exit_ctls = FEXC[31:0];
    c.entry_ctls = FENC[31:0];
    entry(c);
    c.sec_enable = 1'b0;
    c.sec_ctls = 32'hffff_ffff;
    entry(c);
    c.activity = ACT_SHUTDOWN;
    entry(c);
    c.activity = ACT_WAIT_STARTUP;
    c.exit_ctls = 32'h0000_0000;
    entry(c);
    repeat (60) entry(rand_ctl());
    // Raw write, then raising operation forces the held words
    words(1'b0);
    @(posedge ref_clk_i);
    virt_on_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(machine_control_word_o, (mv | MWF) & (MWA | MWF), "held mword");
    check(feature_control_word_o, (fv | FWF) & (FWA | FWF), "held fword");
    words(1'b1);
    timer_run(1'b1, 14, 32'h0000_0003);
    repeat (4) timer_run($urandom % 2, 1 + $urandom % 40, 1 + $urandom % 8);
    final_report();
  end
endmodule
